// File: bench/cec_top_monitor.sv
// Port checker for the error control block
`default_nettype none
module cec_top_monitor #(
	parameter int SEV_W  = 6,
	parameter int INFO_W = 16
) (
	// Clock, reset, enable
	input wire logic              clk_sys,
	input wire logic              rstn,
	input wire logic              ce,
	// Register port
	input wire cec_pkg::cec_bus_t bus,
	input wire logic [31:0]       rdata,
	// Errors, messages, interrupt
	input wire cec_pkg::cec_err_t err,
	input wire logic              msg_valid,
	input wire logic [2:0]        msg_prio,
	input wire logic              irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of control fields, rebuilt from taken writes
	logic [1:0]  dis;
	logic [13:0] c1;
	logic        den;
	wire logic   ok_p = err.prio != 3'h0 && err.prio <= 3'h6;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dis <= 2'h3;
			c1  <= 14'h0000;
			den <= 1'b0;
		end else if (ce && bus.wr) begin
			if (bus.addr == cec_pkg::CEC_OFS_CTRL0) dis <= bus.wdata[3:2];
			if (bus.addr == cec_pkg::CEC_OFS_CTRL1) c1 <= bus.wdata[13:0];
			if (bus.addr == cec_pkg::CEC_OFS_DEV) den <= bus.wdata[0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Properties: one clock domain, so shared clocking and disable
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_msg_cause: assert property (msg_valid |-> $past(err.valid && ce)
		&& msg_prio == $past(err.prio)) else $error("message without cause");
	a_msg_dis_off: assert property (err.valid && ce && dis != 2'h0
		|=> !msg_valid) else $error("message while disabled");
	a_dev_off: assert property (err.valid && ce && !den |=> !msg_valid)
		else $error("message with device enable low");
	a_msg_masked: assert property (err.valid && ce && ok_p
		&& c1[4'(err.prio) + 4'h7] |=> !msg_valid) else $error("masked message sent");
	a_log_masked: assert property (err.valid && ce && ok_p
		&& c1[4'(err.prio) - 4'h1] |=> !msg_valid) else $error("masked log reported");
	a_bad_prio: assert property (err.valid && ce && !ok_p |=> !msg_valid)
		else $error("message for bad priority");
	a_ctrl0_read: assert property (bus.rd && ce && bus.addr == 8'h00
		|=> rdata[3:2] == dis) else $error("disable field readback");
	a_ctrl1_read: assert property (bus.rd && ce && bus.addr == 8'h04
		|=> rdata == {18'h0, c1}) else $error("mask register readback");
endmodule
bind cec_top cec_top_monitor #(.SEV_W(SEV_W), .INFO_W(INFO_W)) u_mon (.clk_sys(clk_sys),
	.rstn(rstn), .ce(ce), .bus(bus), .rdata(rdata), .err(err), .msg_valid(msg_valid),
	.msg_prio(msg_prio), .irq(irq));
`default_nettype wire

// File: bench/cec_top_tb_top.sv
// Self-checking bench for the error control block
`default_nettype none
module cec_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////////////
	// Design ports
	logic              clk_sys = 1'b0;
	logic              rstn    = 1'b0;
	logic              ce      = 1'b1;
	cec_pkg::cec_bus_t bus     = '0;
	cec_pkg::cec_err_t err     = '0;
	logic [31:0]       rdata;
	logic              msg_valid;
	logic [2:0]        msg_prio;
	logic              irq;
	// Tallies
	int                mismatches = 0;
	int                num_checks = 0;
	// Model: disable, status, masks, log, interrupt pair
	logic [1:0]        dis = 2'h3;
	logic [1:0]        sta = 2'h0;
	logic [13:0]       c1  = '0;
	logic              den = 1'b0;
	logic [1:0]        ist = 2'h0;
	logic [1:0]        imk = 2'h0;
	logic [2:0]        lp  = 3'h0;
	logic [15:0]       li  = 16'h0000;
	int                lk  = 1; // Log content undefined after a clear
	always #50 clk_sys = ~clk_sys;
	cec_top uut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .bus(bus), .rdata(rdata),
		.err(err), .msg_valid(msg_valid), .msg_prio(msg_prio), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and close
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [31:0] mrd(input logic [7:0] a);
		case (a)
			8'h00: return {28'h0, dis, sta};
			8'h04: return {18'h0, c1};
			8'h08: return {13'h0, lp, li};
			8'h0C: return {30'h0, ist};
			8'h10: return {30'h0, imk};
			8'h14: return {31'h0, den};
			default: return 32'h0; // Unmapped reads zero
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Bus and error drivers; model follows each taken access
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic c);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		ce <= c;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		ce <= 1'b1;
		if (c) begin
			case (a)
				8'h00: begin
					dis = d[3:2];
					if (d[1:0] == 2'h3) begin
						sta = 2'h0;
						lk = 0;
					end
				end
				8'h04: c1 = d[13:0];
				8'h0C: ist = ist & ~d[1:0];
				8'h10: imk = d[1:0];
				8'h14: den = d[0];
				default: ;
			endcase
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		if (a != 8'h08 || lk != 0) chk(rdata, mrd(a));
	endtask
	task automatic er(input logic [2:0] p, input logic [15:0] i);
		logic lg;
		logic ms;
		@(posedge clk_sys);
		err <= '{valid: 1'b1, prio: p, info: i};
		@(posedge clk_sys);
		err.valid <= 1'b0;
		lg = p != 0 && p <= 6 && !c1[p - 1] && !dis[0] && (sta == 0 || p > lp);
		ms = lg && !c1[p + 7] && dis == 2'h0 && den;
		#1;
		chk(msg_valid, ms);
		if (ms) chk(msg_prio, p);
		if (lg) begin
			sta = ms ? 2'h3 : 2'h1;
			lp = p;
			li = i;
			lk = 1;
			ist = ist | {ms, 1'b1};
		end
	endtask
	task automatic idle();
		@(posedge clk_sys);
		#1;
		chk(irq, |(ist & imk));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int r;
		int a;
		int x;
		r = $urandom(32'h4fd6);
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		// Every place after reset, both unmapped ones included
		for (a = 0; a < 8; a++) rd(8'(a * 4));
		$display("test reset values done");
		// Arm, then each priority code, bad ones too
		wr(8'h14, 32'h1, 1'b1);
		wr(8'h10, 32'h3, 1'b1);
		wr(8'h00, 32'h0, 1'b1);
		for (a = 0; a < 8; a++) begin
			er(3'(a), 16'(a * 16'h1111));
			idle();
		end
		rd(8'h00);
		rd(8'h08);
		$display("test priorities done");
		// Random traffic; disable never gets the invalid code
		for (a = 0; a < 400; a++) begin
			r = $urandom % 6;
			x = $urandom % 3;
			case (r)
				0, 5: er(3'($urandom % 6 + 1), 16'($urandom));
				1: rd(8'($urandom % 7) << 2);
				2: wr(8'h00, {28'h0, (x == 1) ? 2'h3 : 2'(x), ($urandom % 2) ? 2'h3 : 2'h0},
					1'b1);
				3: wr(8'h04, $urandom, ($urandom % 8) != 0);
				default: wr(8'h0C + 8'(x * 4), $urandom, 1'b1);
			endcase
			idle();
		end
		$display("test random traffic done");
		// Reset again in mid-run, with masks, status and log all set
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		dis = 2'h3;
		sta = 2'h0;
		c1  = '0;
		den = 1'b0;
		ist = 2'h0;
		imk = 2'h0;
		lp  = 3'h0;
		li  = 16'h0000;
		lk  = 1;
		for (a = 0; a < 8; a++) rd(8'(a * 4));
		idle();
		$display("test second reset done");
		conclude();
	end
	// Hang guard, well beyond the expected run
	initial begin
		#2000000;
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire

// File: logic/cec_filter.sv
// Severity filter: decides per error whether it logs and whether it reports
`default_nettype none
module cec_filter #(
	parameter int SEV_W = 6
) (
	// Incoming error
	input  wire logic [2:0]       prio,
	// Control fields
	input  wire logic [1:0]       dis,
	input  wire logic [SEV_W-1:0] log_mask,
	input  wire logic [SEV_W-1:0] msg_mask,
	input  wire logic             dev_en,
	// Decisions
	output logic                  do_log,
	output logic                  do_msg
);
	initial begin
		if (SEV_W != cec_pkg::CEC_SEV_W) begin
			$error("Severity width must match the field layout");
		end
	end
	logic [SEV_W-1:0] hit; // One-hot priority decode
	////////////////////////////////////////////////////////////////////////////////
	// Priority n+1 maps to mask bit n
	genvar g;
	generate
		for (g = 0; g < SEV_W; g++) begin : g_dec
			assign hit[g] = (prio == 3'(g + 1));
		end
	endgenerate
	// Disable field gates, masks gate per severity, device enable gates messages
	always_comb begin
		do_log = (hit != '0) && ((hit & log_mask) == '0)             // [RULE7] [RULE13]
			&& (dis == cec_pkg::CEC_DIS_BOTH_ON                  // [RULE1]
			|| dis == cec_pkg::CEC_DIS_NO_MSG);                  // [RULE2] [RULE3]
		do_msg = do_log && ((hit & msg_mask) == '0)                  // [RULE8]
			&& (dis == cec_pkg::CEC_DIS_BOTH_ON)                 // [RULE2]
			&& dev_en;                                           // [RULE5]
	end
endmodule
`default_nettype wire

// File: logic/cec_pkg.sv
// Package: register map, field layout, reset values and carrier types for error control
// How it works
// (RULE1) Disable 00b: log and report errors
// (RULE2) Disable 10b: log, no message
// (RULE3) Disable 11b: neither log nor report
// (RULE4) Setting 11b keeps pending status and log
// (RULE5) Device enable low stops all messages
// (RULE6) Disable field resets to 11b
// (RULE7) Log mask bit n blocks priority n+1 logging
// (RULE8) Report mask bit n blocks priority n+1 messages
// (RULE9) Both severity masks reset to zero
// (RULE10) Software never writes 01b to disable
// (RULE11) Bits 7:6 read back, no effect
// (RULE12) Status 00 none, 01 logged, 11 reported
// (RULE13) Masks apply from the very next error
`default_nettype none
package cec_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] CEC_OFS_CTRL0  = 8'h00;
	localparam logic [7:0] CEC_OFS_CTRL1  = 8'h04;
	localparam logic [7:0] CEC_OFS_LOG    = 8'h08;
	localparam logic [7:0] CEC_OFS_IRQST  = 8'h0C;
	localparam logic [7:0] CEC_OFS_IRQMSK = 8'h10;
	localparam logic [7:0] CEC_OFS_DEV    = 8'h14;
	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CEC_STA_LO   = 0;
	localparam int CEC_DIS_LO   = 2;
	localparam int CEC_LMSK_LO  = 0;
	localparam int CEC_RSV_LO   = 6;
	localparam int CEC_RMSK_LO  = 8;
	localparam int CEC_SEV_W    = 6;
	localparam int CEC_PRIO_W   = 3;
	localparam int CEC_INFO_W   = 16;
	localparam int CEC_LOG_SEV_LO = 16;
	////////////////////////////////////////////////////////////////////////////////
	// Encodings and reset values
	localparam logic [1:0] CEC_DIS_BOTH_ON = 2'h0;
	localparam logic [1:0] CEC_DIS_BAD     = 2'h1;
	localparam logic [1:0] CEC_DIS_NO_MSG  = 2'h2;
	localparam logic [1:0] CEC_DIS_ALL_OFF = 2'h3;
	localparam logic [1:0] CEC_STA_NONE    = 2'h0;
	localparam logic [1:0] CEC_STA_LOGGED  = 2'h1;
	localparam logic [1:0] CEC_STA_REPORTED = 2'h3;
	localparam logic [1:0] CEC_STA_CLEAR   = 2'h3;
	localparam logic [5:0] CEC_MASK_RESET  = 6'h00;
	localparam logic [2:0] CEC_PRIO_NONE   = 3'h0;
	localparam logic [2:0] CEC_PRIO_MAX    = 3'h6;
	// Interrupt status bits
	localparam int CEC_IRQ_LOGGED = 0;
	localparam int CEC_IRQ_MSG    = 1;
	localparam int CEC_IRQ_W      = 2;
	////////////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef struct packed {
		logic       valid; // One-cycle error event
		logic [2:0] prio;  // Severity priority 1..6
		logic [15:0] info; // Error details for the log
	} cec_err_t;
	typedef struct packed {
		logic [7:0]  addr;  // Byte address
		logic [31:0] wdata; // Write data
		logic        wr;    // Write strobe
		logic        rd;    // Read strobe
	} cec_bus_t;
endpackage
`default_nettype wire

// File: logic/cec_regs.sv
// Interrupt status and mask pair: sticky bits, write one to clear
`default_nettype none
module cec_irq #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic         ce,
	// Events and software access
	input  wire logic [W-1:0] events,
	input  wire logic         wr_stat,
	input  wire logic         wr_mask,
	input  wire logic [W-1:0] wdata,
	// State
	output logic [W-1:0]      stat,
	output logic [W-1:0]      mask,
	output logic              irq
);
	initial begin
		if (W < 1) begin
			$error("Interrupt width must be positive");
		end
	end
	typedef struct packed {
		logic [W-1:0] stat; // Sticky events
		logic [W-1:0] mask; // Enable per event
		logic         irq;  // Registered output
	} cec_irq_state_t;
	cec_irq_state_t r, next_r;
	////////////////////////////////////////////////////////////////////////////////
	// Next state: set beats clear in the same cycle
	always_comb begin
		next_r = r;
		if (wr_stat) begin
			next_r.stat = r.stat & ~wdata;
		end
		next_r.stat = next_r.stat | events;
		if (wr_mask) begin
			next_r.mask = wdata;
		end
		next_r.irq = |(next_r.stat & next_r.mask);
	end
	// Register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end
	assign stat = r.stat;
	assign mask = r.mask;
	assign irq  = r.irq;
endmodule
`default_nettype wire

// File: logic/cec_top.sv
// Component error control: control registers, pending status, log and message output
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module cec_top #(
	parameter int SEV_W  = 6,
	parameter int INFO_W = 16
) (
	// Clock, reset, enable
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire logic                 ce,
	// Register port
	input  wire cec_pkg::cec_bus_t    bus,
	output logic [31:0]               rdata,
	// Protocol errors from the component
	input  wire cec_pkg::cec_err_t    err,
	// Error message request to the device, one cycle
	output logic                      msg_valid,
	output logic [2:0]                msg_prio,
	// Interrupt
	output logic                      irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	initial begin
		if (SEV_W != cec_pkg::CEC_SEV_W || INFO_W != cec_pkg::CEC_INFO_W) begin
			$error("Field widths fixed by the register layout");
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// All block state in one struct
	typedef struct packed {
		logic [1:0]       sta;       // Pending status
		logic [1:0]       dis;       // Disable field
		logic [SEV_W-1:0] log_mask;  // Severity logging mask
		logic [1:0]       rsv;       // Preserved bits 7:6
		logic [SEV_W-1:0] msg_mask;  // Severity message mask
		logic             dev_en;    // Device-level error enable
		logic [2:0]       log_prio;  // Logged severity
		logic [INFO_W-1:0] log_info; // Logged details
		logic [31:0]      rdata;     // Read data register
		logic             msg_valid; // Message strobe
		logic [2:0]       msg_prio;  // Message severity
		logic             irq;       // Interrupt level, one cycle behind the pair
	} cec_state_t;
	cec_state_t r, next_r;
	// Decoded accesses
	logic wr0, wr1, wr_dev, wr_ist, wr_imk;
	logic do_log, do_msg;          // Filter decisions
	logic upgrade;                 // New error outranks the log
	logic [cec_pkg::CEC_IRQ_W-1:0] ev, ist, imk;
	logic irq_w;                   // Interrupt level from the pair
	logic [1:0] sta_after_clr;     // Status after a software clear
	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	always_comb begin
		wr0    = bus.wr && bus.addr == cec_pkg::CEC_OFS_CTRL0;
		wr1    = bus.wr && bus.addr == cec_pkg::CEC_OFS_CTRL1;
		wr_dev = bus.wr && bus.addr == cec_pkg::CEC_OFS_DEV;
		wr_ist = bus.wr && bus.addr == cec_pkg::CEC_OFS_IRQST;
		wr_imk = bus.wr && bus.addr == cec_pkg::CEC_OFS_IRQMSK;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Filter sees the current fields, so a mask written earlier already holds
	cec_filter #(
		.SEV_W    (SEV_W)
	) u_filter (
		.prio     (err.prio),
		.dis      (r.dis),
		.log_mask (r.log_mask),
		.msg_mask (r.msg_mask),
		.dev_en   (r.dev_en),
		.do_log   (do_log),
		.do_msg   (do_msg)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Interrupt events: a log captured, a message sent
	always_comb begin
		ev = '0;
		ev[cec_pkg::CEC_IRQ_LOGGED] = err.valid && do_log && upgrade;
		ev[cec_pkg::CEC_IRQ_MSG]    = err.valid && do_msg && upgrade;
	end
	cec_irq #(
		.W       (cec_pkg::CEC_IRQ_W)
	) u_irq (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.events  (ev),
		.wr_stat (wr_ist),
		.wr_mask (wr_imk),
		.wdata   (bus.wdata[cec_pkg::CEC_IRQ_W-1:0]),
		.stat    (ist),
		.mask    (imk),
		.irq     (irq_w)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_r = r;
		next_r.msg_valid = 1'b0;
		// Interrupt level registered again so the output is a flip-flop
		next_r.irq = irq_w;
		// Software clear of status: all ones clears, zeros do nothing
		sta_after_clr = r.sta;
		if (wr0 && bus.wdata[cec_pkg::CEC_STA_LO +: 2] == cec_pkg::CEC_STA_CLEAR) begin
			sta_after_clr = cec_pkg::CEC_STA_NONE;                // [RULE12]
		end
		// Empty log takes any error; a held log takes only a higher priority
		upgrade = (sta_after_clr == cec_pkg::CEC_STA_NONE)
			|| (err.prio > r.log_prio);
		next_r.sta = sta_after_clr;
		// Control register 0: disable field; 01b is kept as written
		if (wr0) begin
			next_r.dis = bus.wdata[cec_pkg::CEC_DIS_LO +: 2];      // [RULE4] [RULE10]
		end
		// Control register 1: masks and preserved bits
		if (wr1) begin
			next_r.log_mask = bus.wdata[cec_pkg::CEC_LMSK_LO +: SEV_W];
			next_r.rsv      = bus.wdata[cec_pkg::CEC_RSV_LO +: 2]; // [RULE11]
			next_r.msg_mask = bus.wdata[cec_pkg::CEC_RMSK_LO +: SEV_W];
		end
		if (wr_dev) begin
			next_r.dev_en = bus.wdata[0];                         // [RULE5]
		end
		// Error capture: event beats a clear in the same cycle
		if (err.valid && do_log && upgrade) begin
			next_r.log_prio = err.prio;                           // [RULE1] [RULE2]
			next_r.log_info = err.info;
			next_r.sta = do_msg ? cec_pkg::CEC_STA_REPORTED
				: cec_pkg::CEC_STA_LOGGED;                    // [RULE12]
			next_r.msg_valid = do_msg;                            // [RULE1] [RULE8]
			next_r.msg_prio  = err.prio;
		end
		// Read data, one cycle later; unmapped reads zero
		next_r.rdata = '0;
		if (bus.rd) begin
			unique case (bus.addr)
				cec_pkg::CEC_OFS_CTRL0: begin
					next_r.rdata[cec_pkg::CEC_STA_LO +: 2] = r.sta;
					next_r.rdata[cec_pkg::CEC_DIS_LO +: 2] = r.dis;
				end
				cec_pkg::CEC_OFS_CTRL1: begin
					next_r.rdata[cec_pkg::CEC_LMSK_LO +: SEV_W] = r.log_mask;
					next_r.rdata[cec_pkg::CEC_RSV_LO +: 2]      = r.rsv; // [RULE11]
					next_r.rdata[cec_pkg::CEC_RMSK_LO +: SEV_W] = r.msg_mask;
				end
				cec_pkg::CEC_OFS_LOG: begin
					next_r.rdata[INFO_W-1:0] = r.log_info;
					next_r.rdata[cec_pkg::CEC_LOG_SEV_LO +: 3] = r.log_prio;
				end
				cec_pkg::CEC_OFS_IRQST: begin
					next_r.rdata[cec_pkg::CEC_IRQ_W-1:0] = ist;
				end
				cec_pkg::CEC_OFS_IRQMSK: begin
					next_r.rdata[cec_pkg::CEC_IRQ_W-1:0] = imk;
				end
				cec_pkg::CEC_OFS_DEV: begin
					next_r.rdata[0] = r.dev_en;
				end
				default: begin
					next_r.rdata = '0;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// State register with reset values
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r          <= '0;
			r.dis      <= cec_pkg::CEC_DIS_ALL_OFF;                   // [RULE6]
			r.log_mask <= cec_pkg::CEC_MASK_RESET;                    // [RULE9]
			r.msg_mask <= cec_pkg::CEC_MASK_RESET;                    // [RULE9]
			r.log_prio <= cec_pkg::CEC_PRIO_NONE;
		end else if (ce) begin
			r <= next_r;
		end
	end
	assign rdata     = r.rdata;
	assign msg_valid = r.msg_valid;
	assign msg_prio  = r.msg_prio;
	assign irq       = r.irq;
endmodule
`default_nettype wire
